//--- logic/fepc_coding_path.v
// 100base-tx coding path: mii nibbles to mlt-3 symbols and back
// assumes mii inputs and line symbols synchronous to sys_clk; one line bit
// takes BIT_CYCLES enabled clocks, standing in for the 125 MHz bit rate
`timescale 1ns/1ns
`include "fepc_consts.vh"

module fepc_coding_path #(
    parameter BIT_CYCLES = `FEPC_BIT_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire tx_en,
    input wire tx_er,
    input wire [3:0] txd,
    output reg tx_take_q,
    output reg [1:0] mlt_tx_q,
    input wire [1:0] mlt_rx,
    output reg rx_nrzi_q,
    output reg rx_bit_stb_q,
    output reg rx_lock_q,
    output reg [3:0] rxd_q,
    output reg rx_dv_q,
    output reg rx_er_q,
    output reg rx_stb_q
);

    // ------------------------------------------------------------------
    // code-group helpers
    // ------------------------------------------------------------------
    // standard data groups
    function [4:0] enc4b5b;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc4b5b = 5'h1E;
                4'h1: enc4b5b = 5'h09;
                4'h2: enc4b5b = 5'h14;
                4'h3: enc4b5b = 5'h15;
                4'h4: enc4b5b = 5'h0A;
                4'h5: enc4b5b = 5'h0B;
                4'h6: enc4b5b = 5'h0E;
                4'h7: enc4b5b = 5'h0F;
                4'h8: enc4b5b = 5'h12;
                4'h9: enc4b5b = 5'h13;
                4'hA: enc4b5b = 5'h16;
                4'hB: enc4b5b = 5'h17;
                4'hC: enc4b5b = 5'h1A;
                4'hD: enc4b5b = 5'h1B;
                4'hE: enc4b5b = 5'h1C;
                default: enc4b5b = 5'h1D;
            endcase
        end
    endfunction

    // decode: bit 4 set means the group is valid data
    function [4:0] dec5b4b;
        input [4:0] g;
        begin
            case (g)
                5'h1E: dec5b4b = 5'h10;
                5'h09: dec5b4b = 5'h11;
                5'h14: dec5b4b = 5'h12;
                5'h15: dec5b4b = 5'h13;
                5'h0A: dec5b4b = 5'h14;
                5'h0B: dec5b4b = 5'h15;
                5'h0E: dec5b4b = 5'h16;
                5'h0F: dec5b4b = 5'h17;
                5'h12: dec5b4b = 5'h18;
                5'h13: dec5b4b = 5'h19;
                5'h16: dec5b4b = 5'h1A;
                5'h17: dec5b4b = 5'h1B;
                5'h1A: dec5b4b = 5'h1C;
                5'h1B: dec5b4b = 5'h1D;
                5'h1C: dec5b4b = 5'h1E;
                5'h1D: dec5b4b = 5'h1F;
                default: dec5b4b = 5'h00;
            endcase
        end
    endfunction

    localparam CNT_W = 8;
    // sized copy, so the phase counts below are cut to the counter on purpose
    localparam [31:0] BIT_CYC_32 = BIT_CYCLES;
    localparam [CNT_W-1:0] BIT_LAST = BIT_CYC_32[CNT_W-1:0] - 1'b1;
    localparam [CNT_W-1:0] BIT_MID = BIT_CYC_32[CNT_W:1];

    // ------------------------------------------------------------------
    // transmit bit timing
    // ------------------------------------------------------------------
    reg [CNT_W-1:0] tx_div_q;
    reg [2:0] tx_bitn_q;
    reg [2:0] tx_st_q;
    reg [4:0] tx_sh_q;
    reg [`FEPC_LFSR_W-1:0] tx_lfsr_q;
    reg tx_nrzi_q;
    reg [1:0] tx_phase_q;
    wire tx_bit_stb = (tx_div_q == BIT_LAST);
    wire tx_grp_stb = tx_bit_stb && (tx_bitn_q == 3'h0);
    wire tx_key = tx_lfsr_q[`FEPC_TAP_HI] ^ tx_lfsr_q[`FEPC_TAP_LO];
    // scrambled bit is data xor key
    wire tx_scr = tx_sh_q[4] ^ tx_key;

    // next code group and state, chosen at a group boundary
    reg [4:0] tx_grp;
    reg [2:0] tx_st_d;
    reg tx_take;
    always @* begin
        tx_grp = `FEPC_CG_IDLE;
        tx_st_d = tx_st_q;
        tx_take = 1'b0;
        case (tx_st_q)
            `FEPC_TX_IDLE: begin
                if (tx_en) begin
                    tx_grp = `FEPC_CG_J;
                    tx_st_d = `FEPC_TX_K;
                    tx_take = 1'b1;
                end
            end
            `FEPC_TX_K: begin
                tx_grp = `FEPC_CG_K;
                tx_st_d = `FEPC_TX_DATA;
                tx_take = 1'b1;
            end
            `FEPC_TX_DATA: begin
                if (tx_en) begin
                    tx_grp = tx_er ? `FEPC_CG_HALT : enc4b5b(txd);
                    tx_take = 1'b1;
                end else begin
                    tx_grp = `FEPC_CG_T;
                    tx_st_d = `FEPC_TX_R;
                end
            end
            `FEPC_TX_R: begin
                tx_grp = `FEPC_CG_R;
                tx_st_d = `FEPC_TX_IDLE;
            end
            default: begin
                tx_st_d = `FEPC_TX_IDLE;
            end
        endcase
    end

    // serialiser, scrambler, nrzi and mlt-3 all step on the bit strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            tx_div_q <= {CNT_W{1'b0}};
            tx_bitn_q <= 3'h0;
            tx_st_q <= `FEPC_TX_IDLE;
            tx_sh_q <= `FEPC_CG_IDLE;
            tx_lfsr_q <= `FEPC_LFSR_SEED;
            tx_nrzi_q <= 1'b0;
            tx_phase_q <= 2'h0;
            tx_take_q <= 1'b0;
            mlt_tx_q <= `FEPC_MLT_ZERO;
        end else if (ce) begin
            tx_div_q <= tx_bit_stb ? {CNT_W{1'b0}} : tx_div_q + 1'b1;
            tx_take_q <= tx_grp_stb && tx_take;
            if (tx_bit_stb) begin
                // parallel groups leave one bit at a time
                if (tx_bitn_q == 3'h0) begin
                    tx_sh_q <= tx_grp;
                    tx_st_q <= tx_st_d;
                    tx_bitn_q <= `FEPC_GROUP_BITS - 3'h1;
                end else begin
                    tx_sh_q <= {tx_sh_q[3:0], 1'b0};
                    tx_bitn_q <= tx_bitn_q - 3'h1;
                end
                // maximal length, never reaches all zero
                tx_lfsr_q <= {tx_lfsr_q[`FEPC_LFSR_W-2:0], tx_key};
                // a one toggles nrzi, each toggle steps mlt-3
                if (tx_scr) begin
                    tx_nrzi_q <= ~tx_nrzi_q;
                    tx_phase_q <= tx_phase_q + 2'h1;
                    case (tx_phase_q)
                        2'h0: mlt_tx_q <= `FEPC_MLT_PLUS;
                        2'h2: mlt_tx_q <= `FEPC_MLT_MINUS;
                        default: mlt_tx_q <= `FEPC_MLT_ZERO;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // receive: mlt-3 to nrzi and clock recovery
    // ------------------------------------------------------------------
    reg [1:0] rx_lvl_q;
    reg rx_nrzi_old_q;
    reg [CNT_W-1:0] rx_ph_q;
    reg rx_last_q;
    reg rx_bit_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            rx_lvl_q <= `FEPC_MLT_ZERO;
            rx_nrzi_q <= 1'b0;
            rx_nrzi_old_q <= 1'b0;
            rx_ph_q <= {CNT_W{1'b0}};
            rx_last_q <= 1'b0;
            rx_bit_q <= 1'b0;
            rx_bit_stb_q <= 1'b0;
        end else if (ce) begin
            rx_lvl_q <= mlt_rx;
            // every level change is one nrzi toggle
            if (mlt_rx != rx_lvl_q) begin
                rx_nrzi_q <= ~rx_nrzi_q;
            end
            rx_nrzi_old_q <= rx_nrzi_q;
            // edges realign the bit phase; free-runs between edges
            if (rx_nrzi_q != rx_nrzi_old_q) begin
                rx_ph_q <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                rx_ph_q <= (rx_ph_q == BIT_LAST) ? {CNT_W{1'b0}} : rx_ph_q + 1'b1;
            end
            rx_bit_stb_q <= (rx_ph_q == BIT_MID);
            // mid-bit sample on recovered clock gives nrz
            if (rx_ph_q == BIT_MID) begin
                rx_last_q <= rx_nrzi_q;
                rx_bit_q <= rx_nrzi_q ^ rx_last_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // receive: descrambler with idle lock
    // ------------------------------------------------------------------
    reg [`FEPC_LFSR_W-1:0] rx_lfsr_q;
    reg [5:0] rx_match_q;
    reg [9:0] rx_sr_q;
    reg rx_st_q;
    reg [2:0] rx_bitn_q;
    reg rx_pend_q;
    wire rx_key = rx_lfsr_q[`FEPC_TAP_HI] ^ rx_lfsr_q[`FEPC_TAP_LO];
    // while hunting, assume idle ones to recover the key bits
    wire rx_key_seen = ~rx_bit_q;
    wire rx_plain = rx_bit_q ^ rx_key;
    wire [9:0] rx_sr_d = {rx_sr_q[8:0], rx_plain};
    wire [4:0] rx_dec = dec5b4b(rx_sr_d[4:0]);

    always @(posedge sys_clk) begin
        if (rst) begin
            rx_lfsr_q <= `FEPC_LFSR_SEED;
            rx_match_q <= 6'h00;
            rx_lock_q <= 1'b0;
            rx_sr_q <= 10'h000;
            rx_st_q <= `FEPC_RX_HUNT;
            rx_bitn_q <= 3'h0;
            rx_pend_q <= 1'b0;
            rxd_q <= 4'h0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rx_stb_q <= 1'b0;
        end else if (ce) begin
            rx_stb_q <= 1'b0;
            // second regenerated preamble nibble after start of stream
            if (rx_pend_q) begin
                rx_pend_q <= 1'b0;
                rx_stb_q <= 1'b1;
            end
            if (rx_bit_stb_q) begin
                // locked: run free; hunting: load from line
                if (rx_lock_q) begin
                    rx_lfsr_q <= {rx_lfsr_q[`FEPC_LFSR_W-2:0], rx_key};
                end else begin
                    rx_lfsr_q <= {rx_lfsr_q[`FEPC_LFSR_W-2:0], rx_key_seen};
                    rx_match_q <= (rx_key == rx_key_seen) ? rx_match_q + 6'h01 : 6'h00;
                    rx_lock_q <= (rx_match_q == `FEPC_LOCK_BITS);
                end
                if (rx_lock_q) begin
                    rx_sr_q <= rx_sr_d;
                end
                case (rx_st_q)
                    `FEPC_RX_HUNT: begin
                        // J then K marks both start and group alignment
                        if (rx_lock_q && rx_sr_d == `FEPC_JK_PAIR) begin
                            rx_st_q <= `FEPC_RX_FRAME;
                            rx_bitn_q <= `FEPC_GROUP_BITS - 3'h1;
                            rxd_q <= `FEPC_PRE_NIBBLE;
                            rx_dv_q <= 1'b1;
                            rx_er_q <= 1'b0;
                            rx_stb_q <= 1'b1;
                            rx_pend_q <= 1'b1;
                        end
                    end
                    `FEPC_RX_FRAME: begin
                        if (rx_bitn_q == 3'h0) begin
                            rx_bitn_q <= `FEPC_GROUP_BITS - 3'h1;
                            if (rx_sr_d[4:0] == `FEPC_CG_T ||
                                rx_sr_d[4:0] == `FEPC_CG_IDLE) begin
                                // end of stream, or idle cutting the frame short
                                rx_st_q <= `FEPC_RX_HUNT;
                                rx_dv_q <= 1'b0;
                                rx_er_q <= (rx_sr_d[4:0] == `FEPC_CG_IDLE);
                                rx_stb_q <= 1'b1;
                            end else begin
                                // decoded nibble out to the mac
                                rxd_q <= rx_dec[3:0];
                                rx_er_q <= ~rx_dec[4];
                                rx_stb_q <= 1'b1;
                            end
                        end else begin
                            rx_bitn_q <= rx_bitn_q - 3'h1;
                        end
                    end
                    default: begin
                        rx_st_q <= `FEPC_RX_HUNT;
                    end
                endcase
            end
        end
    end

endmodule // fepc_coding_path

//--- logic/fepc_consts.vh
// constants of the 100base-tx coding path: code groups, scrambler, states
// assumes inclusion by fepc_coding_path.v only; one system clock domain
`ifndef FEPC_CONSTS_VH
`define FEPC_CONSTS_VH

// ----------------------------------------------------------------------
// control code groups, first line bit in bit 4
// ----------------------------------------------------------------------
`define FEPC_CG_IDLE 5'h1F
`define FEPC_CG_J 5'h18
`define FEPC_CG_K 5'h11
`define FEPC_CG_T 5'h0D
`define FEPC_CG_R 5'h07
`define FEPC_CG_HALT 5'h04
`define FEPC_JK_PAIR 10'h311

// ----------------------------------------------------------------------
// scrambler
// ----------------------------------------------------------------------
`define FEPC_LFSR_W 11
`define FEPC_LFSR_SEED 11'h7FF
`define FEPC_TAP_HI 10
`define FEPC_TAP_LO 8
`define FEPC_LOCK_BITS 6'h30

// ----------------------------------------------------------------------
// timing and line symbols
// ----------------------------------------------------------------------
`define FEPC_LINE_RATE_MHZ 125
`define FEPC_BIT_CYCLES 4
`define FEPC_GROUP_BITS 3'h5
`define FEPC_PRE_NIBBLE 4'h5
`define FEPC_MLT_ZERO 2'h0
`define FEPC_MLT_PLUS 2'h1
`define FEPC_MLT_MINUS 2'h3

// ----------------------------------------------------------------------
// state codes
// ----------------------------------------------------------------------
`define FEPC_TX_IDLE 3'h0
`define FEPC_TX_K 3'h1
`define FEPC_TX_DATA 3'h2
`define FEPC_TX_R 3'h3
`define FEPC_RX_HUNT 1'b0
`define FEPC_RX_FRAME 1'b1

`endif

//--- tb/fepc_coding_path_asserts.sv
// checker for the coding path: relations between its ports over time
// assumes one sys_clk domain, rst synchronous active high; ce low freezes the block
`timescale 1ns/1ns
module fepc_coding_path_chk #(
    parameter BIT_CYCLES = 4
) (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire tx_en,
    input wire tx_er,
    input wire [3:0] txd,
    input wire tx_take_q,
    input wire [1:0] mlt_tx_q,
    input wire [1:0] mlt_rx,
    input wire rx_nrzi_q,
    input wire rx_bit_stb_q,
    input wire rx_lock_q,
    input wire [3:0] rxd_q,
    input wire rx_dv_q,
    input wire rx_er_q,
    input wire rx_stb_q
);
    // ------------------------------------------------------------------
    // assertions, all in the system clock domain
    // ------------------------------------------------------------------
    // frozen pulses still stand one cycle after ce returns, so skip that cycle too
    reg ce_q = 1'b0;
    always @(posedge sys_clk) begin
        ce_q <= ce;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !ce || !ce_q);
    // take is a pulse and no second take follows within 8 cycles (a group is 20 cycles)
    take_spacing_a: assert property (tx_take_q |=> (!tx_take_q) [*8])
        else $error("take pulses too close");
    take_pulse_a: assert property (tx_take_q |=> !tx_take_q)
        else $error("take pulse longer than one cycle");
    mlt_code_a: assert property (mlt_tx_q != 2'h2)
        else $error("illegal line symbol");
    // mlt-3 only steps between zero and a nonzero level
    mlt_step_a: assert property ($changed(mlt_tx_q) |->
        ((mlt_tx_q == 2'h0) != ($past(mlt_tx_q) == 2'h0)))
        else $error("line symbol skipped zero");
    // a symbol stands one bit period of four cycles
    mlt_hold_a: assert property ($changed(mlt_tx_q) |=> $stable(mlt_tx_q) [*3])
        else $error("line symbol too short");
    nrzi_follow_a: assert property ($changed(mlt_rx) |-> ##[1:3] $changed(rx_nrzi_q))
        else $error("nrzi level did not toggle");
    bit_clock_a: assert property (rx_bit_stb_q |=> !rx_bit_stb_q)
        else $error("bit strobe longer than one cycle");
    lock_hold_a: assert property (rx_lock_q |=> rx_lock_q)
        else $error("lock dropped");
    unlocked_quiet_a: assert property (!rx_lock_q |-> !rx_dv_q)
        else $error("frame before lock");
    dv_strobe_a: assert property ($changed(rx_dv_q) |-> rx_stb_q)
        else $error("frame flag changed without strobe");
    // main scenarios
    take_c: cover property (tx_take_q);
    lock_c: cover property ($rose(rx_lock_q));
    data_c: cover property (rx_stb_q && rx_dv_q);
    err_c: cover property (rx_stb_q && rx_er_q);
endmodule // fepc_coding_path_chk
bind fepc_coding_path fepc_coding_path_chk #(.BIT_CYCLES(BIT_CYCLES)) i_chk (.sys_clk, .rst,
    .ce, .tx_en, .tx_er, .txd, .tx_take_q, .mlt_tx_q, .mlt_rx, .rx_nrzi_q, .rx_bit_stb_q,
    .rx_lock_q, .rxd_q, .rx_dv_q, .rx_er_q, .rx_stb_q);

//--- tb/fepc_mac_model.sv
// media access controller model: sends queued nibbles, {error, nibble}
// assumes the bench fills q away from the rising edge, after reset
`timescale 1ns/1ns
module fepc_mac_model (
    input wire sys_clk,
    input wire rst,
    input wire tx_take_q,
    output reg tx_en,
    output reg tx_er,
    output reg [3:0] txd
);
    // ------------------------------------------------------------------
    // nibble queue and drivers
    // ------------------------------------------------------------------
    reg [4:0] q[$];
    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd = 4'h0;
    end
    // hold each nibble until taken; idle data flips so stale values never match
    always @(posedge sys_clk) begin
        if (rst)
            q.delete();
        else if (tx_take_q && q.size() != 0)
            void'(q.pop_front());
        tx_en <= (q.size() != 0) && !rst;
        if (q.size() != 0 && !rst) begin
            tx_er <= q[0][4];
            txd <= q[0][3:0];
        end else begin
            tx_er <= 1'b0;
            txd <= ~txd;
        end
    end
endmodule // fepc_mac_model

//--- tb/test_fepc_coding_path.sv
// bench for the coding path: mac model in front, line looped back
// assumes the default bit period of four cycles; ce dropped only between frames
`timescale 1ns/1ns
module test_fepc_coding_path;
    // ------------------------------------------------------------------
    // clock, reset, instances
    // ------------------------------------------------------------------
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    wire tx_en, tx_er, tx_take_q, rx_nrzi_q, rx_bit_stb_q, rx_lock_q, rx_dv_q, rx_er_q, rx_stb_q;
    wire [3:0] txd, rxd_q;
    wire [1:0] mlt_tx_q;
    integer miscompares = 0, comparisons = 0, seed = 32'h9e78, cycles = 0, frames = 0;
    reg [4:0] exp_q[$];
    reg [4:0] e;
    reg in_frame = 1'b0;
    always #25 sys_clk = ~sys_clk;
    // loopback: the line output feeds the receiver, so both halves must agree
    fepc_coding_path #(.BIT_CYCLES(4)) i_fepc_coding_path (.sys_clk(sys_clk), .rst(rst),
        .ce(ce), .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_take_q(tx_take_q),
        .mlt_tx_q(mlt_tx_q), .mlt_rx(mlt_tx_q), .rx_nrzi_q(rx_nrzi_q),
        .rx_bit_stb_q(rx_bit_stb_q), .rx_lock_q(rx_lock_q), .rxd_q(rxd_q), .rx_dv_q(rx_dv_q),
        .rx_er_q(rx_er_q), .rx_stb_q(rx_stb_q));
    fepc_mac_model i_fepc_mac_model (.sys_clk(sys_clk), .rst(rst), .tx_take_q(tx_take_q),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd));
    // ------------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------------
    task end_of_test;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task cmp_nib(input [3:0] got, input [3:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: nibble %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cmp_flag(input got, input exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    // ------------------------------------------------------------------
    // receive model: every strobe in a frame pops one expected nibble
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: run timed out", $time);
            end_of_test;
        end else if (!rst && rx_stb_q === 1'b1) begin
            if (rx_dv_q === 1'b1) begin
                in_frame = 1'b1;
                if (exp_q.size() == 0)
                    cmp_flag(1'b1, 1'b0);
                else begin
                    e = exp_q.pop_front();
                    cmp_flag(rx_er_q, e[4]);
                    if (!e[4])
                        cmp_nib(rxd_q, e[3:0]);
                end
            end else if (in_frame) begin
                in_frame = 1'b0;
                frames = frames + 1;
                cmp_flag(rx_er_q, 1'b0);
                cmp_flag(exp_q.size() == 0, 1'b1);
            end
        end
    end
    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    // reset, check quiet outputs, then wait for descrambler lock
    task reset_lock;
        integer w;
        begin
            rst <= 1'b1;
            repeat (5) @(posedge sys_clk);
            rst <= 1'b0;
            exp_q.delete();
            in_frame = 1'b0;
            cmp_flag(mlt_tx_q === 2'h0 && rx_lock_q === 1'b0 && rx_dv_q === 1'b0, 1'b1);
            for (w = 0; w < 2000 && rx_lock_q !== 1'b1; w = w + 1)
                @(posedge sys_clk);
            cmp_flag(rx_lock_q, 1'b1);
        end
    endtask
    // two preamble nibbles then n data nibbles; walk sends 0..15, bad marks a halt
    task send_frame(input integer n, input integer bad, input integer walk);
        integer k, w, r;
        reg [4:0] v;
        begin
            @(negedge sys_clk);
            for (k = -2; k < n; k = k + 1) begin
                r = $random(seed);
                v = (k < 0) ? 5'h0_5 : {k == bad, walk ? k[3:0] : r[3:0]};
                exp_q.push_back(v);
                i_fepc_mac_model.q.push_back(v);
            end
            k = frames;
            for (w = 0; w < n * 40 + 600 && frames == k; w = w + 1)
                @(posedge sys_clk);
            cmp_flag(frames != k, 1'b1);
            $display("frame of %0d nibbles done at %0t", n, $time);
        end
    endtask
    // ce low for a random while: line symbol, nrzi level and lock must stand still
    task freeze;
        integer n;
        reg [1:0] m;
        reg l;
        begin
            n = 3 + ($random(seed) & 15);
            ce <= 1'b0;
            @(posedge sys_clk);
            m = mlt_tx_q;
            l = rx_nrzi_q;
            repeat (n) @(posedge sys_clk);
            cmp_flag(mlt_tx_q === m && rx_nrzi_q === l && rx_lock_q === 1'b1, 1'b1);
            ce <= 1'b1;
            $display("freeze of %0d cycles done at %0t", n, $time);
        end
    endtask
    initial begin
        reset_lock;
        send_frame(8, -1, 0);
        send_frame(16, -1, 1);
        freeze;
        send_frame(6, 3, 0);
        send_frame(1, -1, 0);
        reset_lock;
        send_frame(12, -1, 0);
        end_of_test;
    end
endmodule // test_fepc_coding_path
